// *** dv/testbench.sv ***
// Purpose: Self-checking bench
// Assumes: Master model issues requests
// Notes: Answers queued, compared by a watcher
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk, rst_n, wr, rd, ack, err, dol, flt, drv, sel;
	logic [15:0] idx, wd, rdat, src, fld, kind, y;
	logic [7:0] pvd, fvd;
	logic [17:0] q[$];
	logic [31:0] seed = 32'h0000D918;
	logic [15:0] ri[11], rv[11];
	int fails = 0, checked = 0, x;
	vocf_config_objects DUT (.CLK_SYS_I(clk), .RESETN_I(rst_n), .OBJ_WR_I(wr), .OBJ_RD_I(rd),
		.OBJ_INDEX_I(idx), .OBJ_WDATA_I(wd), .OBJ_RDATA_O(rdat), .OBJ_ACK_O(ack), .OBJ_ERR_O(err),
		.DO_LOGIC_I(dol), .FAULT_I(flt), .DO_DRIVE_O(drv), .SRC_MSG_SEL_I(sel), .SRC_VALUE_I(src),
		.FIELD_VALUE_O(fld), .OUTPUT_KIND_O(kind), .INPUT_DECIMALS_O(pvd), .FIELD_DECIMALS_O(fvd));
	vocf_master MST (.clk_i(clk), .wr_o(wr), .rd_o(rd), .idx_o(idx), .wd_o(wd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd
	function automatic logic [15:0] sc(int v, int li, int lo, int hi, int uo);
		if (v <= li) return 16'(lo);
		if (v >= hi) return 16'(uo);
		return 16'(lo + (v - li) * (uo - lo) / (hi - li));
	endfunction : sc
	task automatic check(input string n, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask : check
	task automatic req(input logic w, input logic [15:0] i, input logic [15:0] d, input logic e, input logic [15:0] r);
		q.push_back({w, e, r});
		MST.xfer(w, i, d);
	endtask : req
	task automatic give_verdict();
		if (fails == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	always @(negedge clk) begin : watch
		logic [17:0] e;
		if (rst_n && ack) begin
			e = q.pop_front();
			check("err", 16'(err), 16'(e[16]));
			if (!e[17]) check("rdata", rdat, e[15:0]);
		end
	end
	initial begin
		rst_n = 1'b0;
		{dol, flt, sel, src} = 19'h0;
		ri = '{16'h6240, 16'h6250, 16'h6260, 16'h6302, 16'h6310, 16'h6332, 16'h7300, 16'h7320, 16'h7321, 16'h7322, 16'h7323};
		rv = '{16'h0000, 16'h0001, 16'h0001, 16'h0003, 16'h0014, 16'h0000, 16'h0000, 16'h012C, 16'h012C, 16'h05DC, 16'h05DC};
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		for (int k = 0; k < 11; k++) req(0, ri[k], 16'h0000, 0, rv[k]);
		req(0, 16'h6000, 16'h0000, 1, 16'h0000);
		for (int k = 0; k < 20; k++) begin
			x = int'(rnd() % 16'h07D0) - 200;
			src = 16'(x);
			repeat (2) @(negedge clk);
			check("field", fld, sc(x, 300, 300, 1500, 1500));
		end
		req(1, 16'h7320, 16'hFF9C, 0, 16'h0000);
		req(1, 16'h7322, 16'h02BC, 0, 16'h0000);
		req(1, 16'h7321, 16'h03E8, 0, 16'h0000);
		req(1, 16'h7323, 16'h00C8, 0, 16'h0000);
		sel = 1'b1;
		for (int k = 0; k < 20; k++) begin
			x = int'(rnd() % 16'h04B0) - 300;
			src = ~16'(x);
			req(1, 16'h7300, 16'(x), 0, 16'h0000);
			@(negedge clk);
			check("field", fld, sc(x, -100, 1000, 700, 200));
		end
		y = fld;
		req(0, 16'h7330, 16'h0000, 0, y);
		req(1, 16'h7330, 16'h0000, 1, 16'h0000);
		for (int v = 0; v < 6; v++) begin
			req(1, 16'h6302, 16'(v), v > 4, 16'h0000);
			req(1, 16'h6332, 16'(v ^ 1), v == 4, 16'h0000);
		end
		check("field decimals", 16'(fvd), 16'h0004);
		check("input decimals", 16'(pvd), 16'h0004);
		check("field", fld, y);
		y = rnd();
		req(1, 16'h6310, y, 0, 16'h0000);
		check("kind", kind, y);
		for (int p = 0; p < 3; p++) for (int m = 0; m < 3; m++) for (int s = 0; s < 2; s++) begin
			req(1, 16'h6240, 16'(p), 0, 16'h0000);
			req(1, 16'h6250, 16'(m), 0, 16'h0000);
			req(1, 16'h6260, 16'(s), 0, 16'h0000);
			for (int f = 0; f < 4; f++) begin
				{flt, dol} = 2'(f);
				repeat (2) @(negedge clk);
				check("drive", 16'(drv), (f > 1 && m == 1) ? 16'(s) : 16'(f % 2 ^ (p == 1)));
			end
		end
		check("pending", 16'(q.size()), 16'h0000);
		give_verdict();
	end
endmodule : testbench
bind vocf_config_objects vocf_props u_props (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .OBJ_WR_I(OBJ_WR_I),
	.OBJ_RD_I(OBJ_RD_I), .OBJ_INDEX_I(OBJ_INDEX_I), .OBJ_WDATA_I(OBJ_WDATA_I), .OBJ_ACK_O(OBJ_ACK_O),
	.OBJ_ERR_O(OBJ_ERR_O), .OUTPUT_KIND_O(OUTPUT_KIND_O), .INPUT_DECIMALS_O(INPUT_DECIMALS_O));
`default_nettype wire

// *** dv/vocf_master.sv ***
// Purpose: Network master model
// Assumes: One request cycle each
// Notes: Idle lines carry inverted values
`timescale 1ns/1ns
`default_nettype none
module vocf_master (
	// Clock
	input wire logic clk_i,
	// Requests
	output logic wr_o,
	output logic rd_o,
	output logic [15:0] idx_o,
	output logic [15:0] wd_o
);
	initial {wr_o, rd_o, idx_o, wd_o} = 34'h0;
	task automatic xfer(input logic w, input logic [15:0] i, input logic [15:0] d);
		@(negedge clk_i);
		{wr_o, rd_o, idx_o, wd_o} = {w, !w, i, d};
		@(negedge clk_i);
		// Stale index or data must not pass as valid
		{wr_o, rd_o, idx_o, wd_o} = {2'b00, ~i, ~d};
	endtask : xfer
endmodule : vocf_master
`default_nettype wire

// *** dv/vocf_props.sv ***
// Purpose: Checker of object access
// Assumes: Sees top ports only
// Notes: One clock domain
`timescale 1ns/1ns
`default_nettype none
module vocf_props (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RESETN_I,
	// Object access
	input wire logic OBJ_WR_I,
	input wire logic OBJ_RD_I,
	input wire logic [15:0] OBJ_INDEX_I,
	input wire logic [15:0] OBJ_WDATA_I,
	input wire logic OBJ_ACK_O,
	input wire logic OBJ_ERR_O,
	// Settings
	input wire logic [15:0] OUTPUT_KIND_O,
	input wire logic [7:0] INPUT_DECIMALS_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);
	wire logic wp = OBJ_WR_I && OBJ_INDEX_I == vocf_pkg::IDX_INPUT_DECIMALS;
	wire logic wk = OBJ_WR_I && OBJ_INDEX_I == vocf_pkg::IDX_OUT_KIND;
	// Above 4 the setting must stay put; the whole word counts, as upper bits are refused too
	wire logic big = OBJ_WDATA_I > 16'h0004;
	property p_ack; OBJ_WR_I || OBJ_RD_I |=> OBJ_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_idle; !OBJ_WR_I && !OBJ_RD_I |=> !OBJ_ACK_O; endproperty
	a_idle: assert property (p_idle) else $error("ack stray");
	property p_err; OBJ_ERR_O |-> OBJ_ACK_O; endproperty
	a_err: assert property (p_err) else $error("err alone");
	property p_pvwr; wp && !big |=> INPUT_DECIMALS_O == $past(OBJ_WDATA_I[7:0]) && !OBJ_ERR_O; endproperty
	a_pvwr: assert property (p_pvwr) else $error("input decimals write");
	property p_pvref; wp && big |=> OBJ_ERR_O; endproperty
	a_pvref: assert property (p_pvref) else $error("input decimals refuse");
	property p_pvkeep; !wp || big |=> $stable(INPUT_DECIMALS_O); endproperty
	a_pvkeep: assert property (p_pvkeep) else $error("input decimals change");
	property p_kind; wk |=> OUTPUT_KIND_O == $past(OBJ_WDATA_I); endproperty
	a_kind: assert property (p_kind) else $error("kind write");
	property p_kkeep; !wk |=> $stable(OUTPUT_KIND_O); endproperty
	a_kkeep: assert property (p_kkeep) else $error("kind change");
	c_ref: cover property (wp && big);
	c_kind: cover property (wk);
	c_rd: cover property (OBJ_RD_I ##1 OBJ_ACK_O);
endmodule : vocf_props
`default_nettype wire

// *** logic/vocf_config_objects.sv ***
// Purpose: Output configuration objects and output logic of a valve controller
// Assumes: Object requests arrive synchronous to CLK_SYS_I from the network stack
// Notes: Requests are answered one cycle later on OBJ_ACK_O
`timescale 1ns/1ns
`default_nettype none
module vocf_config_objects (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RESETN_I,
	// Object access
	input wire logic OBJ_WR_I,
	input wire logic OBJ_RD_I,
	input wire logic [15:0] OBJ_INDEX_I,
	input wire logic [15:0] OBJ_WDATA_I,
	output logic [15:0] OBJ_RDATA_O,
	output logic OBJ_ACK_O,
	output logic OBJ_ERR_O,
	// Digital output
	input wire logic DO_LOGIC_I,
	input wire logic FAULT_I,
	output logic DO_DRIVE_O,
	// Proportional output
	input wire logic SRC_MSG_SEL_I,
	input wire logic [15:0] SRC_VALUE_I,
	output logic [15:0] FIELD_VALUE_O,
	output logic [15:0] OUTPUT_KIND_O,
	output logic [7:0] INPUT_DECIMALS_O,
	output logic [7:0] FIELD_DECIMALS_O
);
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] polarity_ff;
	logic [7:0] fault_mode_ff;
	logic fault_state_ff;
	logic [7:0] input_decimals_ff;
	logic [15:0] out_kind_ff;
	logic [7:0] field_decimals_ff;
	logic [15:0] proc_input_ff;
	logic [15:0] lower_in_ff;
	logic [15:0] lower_out_ff;
	logic [15:0] upper_in_ff;
	logic [15:0] upper_out_ff;
	logic [15:0] field_ff;
	logic drive_ff;
	logic [15:0] rdata_ff;
	logic ack_ff;
	logic err_ff;
	logic decimals_ok;
	logic mapped;
	logic wr_ok;
	logic [15:0] nxt_rdata;
	logic [15:0] nxt_field;
	logic nxt_drive;

	function automatic logic dec_valid(input logic [15:0] v);
		dec_valid = v <= {8'h00, vocf_pkg::DECIMALS_MAX};
	endfunction : dec_valid

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	always_comb begin
		mapped = 1'b1;
		decimals_ok = 1'b1;
		nxt_rdata = 16'h0000;
		unique case (OBJ_INDEX_I)
			vocf_pkg::IDX_POLARITY: nxt_rdata = {8'h00, polarity_ff};
			vocf_pkg::IDX_FAULT_MODE: nxt_rdata = {8'h00, fault_mode_ff};
			vocf_pkg::IDX_FAULT_STATE: nxt_rdata = {15'h0000, fault_state_ff};
			vocf_pkg::IDX_INPUT_DECIMALS: begin
				nxt_rdata = {8'h00, input_decimals_ff};
				decimals_ok = dec_valid(OBJ_WDATA_I);
			end
			vocf_pkg::IDX_OUT_KIND: nxt_rdata = out_kind_ff;
			vocf_pkg::IDX_FIELD_DECIMALS: begin
				nxt_rdata = {8'h00, field_decimals_ff};
				decimals_ok = dec_valid(OBJ_WDATA_I);
			end
			vocf_pkg::IDX_PROC_INPUT: nxt_rdata = proc_input_ff;
			vocf_pkg::IDX_LOWER_IN: nxt_rdata = lower_in_ff;
			vocf_pkg::IDX_LOWER_OUT: nxt_rdata = lower_out_ff;
			vocf_pkg::IDX_UPPER_IN: nxt_rdata = upper_in_ff;
			vocf_pkg::IDX_UPPER_OUT: nxt_rdata = upper_out_ff;
			vocf_pkg::IDX_FIELD_OUT: begin
				nxt_rdata = field_ff;
				decimals_ok = 1'b0;
			end
			default: mapped = 1'b0;
		endcase
		// Field output is read-only, so a write to it is refused
		wr_ok = OBJ_WR_I && mapped && decimals_ok;
	end

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rdata_ff <= 16'h0000;
			ack_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			ack_ff <= OBJ_WR_I || OBJ_RD_I;
			err_ff <= (OBJ_WR_I && !wr_ok) || (OBJ_RD_I && !OBJ_WR_I && !mapped);
			if (OBJ_RD_I) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// Object storage
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			polarity_ff <= vocf_pkg::RST_POLARITY;
			fault_mode_ff <= vocf_pkg::RST_FAULT_MODE;
			fault_state_ff <= vocf_pkg::RST_FAULT_STATE;
			input_decimals_ff <= vocf_pkg::RST_INPUT_DECIMALS;
			out_kind_ff <= vocf_pkg::RST_OUT_KIND;
			field_decimals_ff <= vocf_pkg::RST_FIELD_DECIMALS;
			proc_input_ff <= vocf_pkg::RST_PROC_INPUT;
			lower_in_ff <= vocf_pkg::RST_LOWER_IN;
			lower_out_ff <= vocf_pkg::RST_LOWER_OUT;
			upper_in_ff <= vocf_pkg::RST_UPPER_IN;
			upper_out_ff <= vocf_pkg::RST_UPPER_OUT;
		end else if (wr_ok) begin
			unique case (OBJ_INDEX_I)
				vocf_pkg::IDX_POLARITY: polarity_ff <= OBJ_WDATA_I[7:0];
				vocf_pkg::IDX_FAULT_MODE: fault_mode_ff <= OBJ_WDATA_I[7:0];
				vocf_pkg::IDX_FAULT_STATE: fault_state_ff <= OBJ_WDATA_I[0];
				vocf_pkg::IDX_INPUT_DECIMALS: input_decimals_ff <= OBJ_WDATA_I[7:0];
				vocf_pkg::IDX_OUT_KIND: out_kind_ff <= OBJ_WDATA_I;
				vocf_pkg::IDX_FIELD_DECIMALS: field_decimals_ff <= OBJ_WDATA_I[7:0];
				vocf_pkg::IDX_PROC_INPUT: proc_input_ff <= OBJ_WDATA_I;
				vocf_pkg::IDX_LOWER_IN: lower_in_ff <= OBJ_WDATA_I;
				vocf_pkg::IDX_LOWER_OUT: lower_out_ff <= OBJ_WDATA_I;
				vocf_pkg::IDX_UPPER_IN: upper_in_ff <= OBJ_WDATA_I;
				vocf_pkg::IDX_UPPER_OUT: upper_out_ff <= OBJ_WDATA_I;
				default: polarity_ff <= polarity_ff;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Digital output
	// ---------------------------------------------------------------
	always_comb begin
		if (FAULT_I && fault_mode_ff == vocf_pkg::FAULT_MODE_SUBST) begin
			nxt_drive = fault_state_ff;
		end else begin
			nxt_drive = DO_LOGIC_I ^ (polarity_ff == vocf_pkg::POLARITY_INVERT);
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			drive_ff <= 1'b0;
		end else begin
			drive_ff <= nxt_drive;
		end
	end

	// ---------------------------------------------------------------
	// Proportional output scaling
	// ---------------------------------------------------------------
	// Input and points share one resolution, so decimals cancel in the ratio
	logic signed [15:0] x_in;
	logic signed [16:0] dx;
	logic signed [16:0] dy;
	logic signed [16:0] span;
	logic signed [33:0] prod;
	logic signed [33:0] quot;
	always_comb begin
		x_in = SRC_MSG_SEL_I ? $signed(proc_input_ff) : $signed(SRC_VALUE_I);
		dx = $signed({x_in[15], x_in}) - $signed({lower_in_ff[15], lower_in_ff});
		dy = $signed({upper_out_ff[15], upper_out_ff}) - $signed({lower_out_ff[15], lower_out_ff});
		span = $signed({upper_in_ff[15], upper_in_ff}) - $signed({lower_in_ff[15], lower_in_ff});
		prod = 34'(dx * dy);
		quot = 34'sd0;
		if (x_in <= $signed(lower_in_ff) || span <= 17'sd0) begin
			// Bad point order from the master falls back to the lower value
			nxt_field = lower_out_ff;
		end else if (x_in >= $signed(upper_in_ff)) begin
			nxt_field = upper_out_ff;
		end else begin
			quot = prod / 34'(span);
			nxt_field = 16'(quot + 34'($signed(lower_out_ff)));
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			field_ff <= vocf_pkg::RST_LOWER_OUT;
		end else begin
			field_ff <= nxt_field;
		end
	end

	assign OBJ_RDATA_O = rdata_ff;
	assign OBJ_ACK_O = ack_ff;
	assign OBJ_ERR_O = err_ff;
	assign DO_DRIVE_O = drive_ff;
	assign FIELD_VALUE_O = field_ff;
	assign OUTPUT_KIND_O = out_kind_ff;
	assign INPUT_DECIMALS_O = input_decimals_ff;
	assign FIELD_DECIMALS_O = field_decimals_ff;
endmodule : vocf_config_objects
`default_nettype wire

// *** logic/vocf_pkg.sv ***
// Purpose: Shared constants for the output configuration objects
// Assumes: Object indices are used as addresses
// Notes: Widths follow the object data types
package vocf_pkg;
	// ---------------------------------------------------------------
	// Object indices
	// ---------------------------------------------------------------
	localparam logic [15:0] IDX_POLARITY = 16'h6240;
	localparam logic [15:0] IDX_FAULT_MODE = 16'h6250;
	localparam logic [15:0] IDX_FAULT_STATE = 16'h6260;
	localparam logic [15:0] IDX_INPUT_DECIMALS = 16'h6302;
	localparam logic [15:0] IDX_OUT_KIND = 16'h6310;
	localparam logic [15:0] IDX_FIELD_DECIMALS = 16'h6332;
	localparam logic [15:0] IDX_PROC_INPUT = 16'h7300;
	localparam logic [15:0] IDX_LOWER_IN = 16'h7320;
	localparam logic [15:0] IDX_LOWER_OUT = 16'h7321;
	localparam logic [15:0] IDX_UPPER_IN = 16'h7322;
	localparam logic [15:0] IDX_UPPER_OUT = 16'h7323;
	localparam logic [15:0] IDX_FIELD_OUT = 16'h7330;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_POLARITY = 8'h00;
	localparam logic [7:0] RST_FAULT_MODE = 8'h01;
	localparam logic RST_FAULT_STATE = 1'b1;
	localparam logic [7:0] RST_INPUT_DECIMALS = 8'h03;
	localparam logic [15:0] RST_OUT_KIND = 16'h0014;
	localparam logic [7:0] RST_FIELD_DECIMALS = 8'h00;
	localparam logic [15:0] RST_PROC_INPUT = 16'h0000;
	localparam logic [15:0] RST_LOWER_IN = 16'h012C;
	localparam logic [15:0] RST_LOWER_OUT = 16'h012C;
	localparam logic [15:0] RST_UPPER_IN = 16'h05DC;
	localparam logic [15:0] RST_UPPER_OUT = 16'h05DC;
	// ---------------------------------------------------------------
	// Field encodings
	// ---------------------------------------------------------------
	localparam logic [7:0] POLARITY_INVERT = 8'h01;
	localparam logic [7:0] FAULT_MODE_SUBST = 8'h01;
	localparam logic [7:0] DECIMALS_MAX = 8'h04;
endpackage : vocf_pkg
